/* File: common/fmr_pkg.sv */
// Shared constants, register map and types of the fault monitor.
// Assumes an 8-bit register port with a 4-bit word address.
package fmr_pkg;

    localparam int AW = 4;
    localparam int DW = 8;

    // Register word addresses
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_RCAUSE = 4'h1;
    localparam logic [3:0] A_EXCR   = 4'h2;
    localparam logic [3:0] A_STAT   = 4'h3;
    localparam logic [3:0] A_MASK   = 4'h4;
    localparam logic [3:0] A_HV     = 4'h5;
    localparam logic [3:0] A_LIM0   = 4'h6;

    // Control fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_INV     = 2;
    localparam int CTRL_SEN_LSB = 4;

    // Status and mask bit positions
    localparam int ST_EXC  = 0;
    localparam int ST_CORR = 1;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] LIM_RST  = 8'hff;

    // Light detector selection codes
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;

    typedef enum logic [2:0] {RC_POR, RC_VOLT, RC_FREQ, RC_TEMP, RC_LIGHT, RC_ROM} fmr_rcause_t;

    typedef enum logic [3:0] {EX_NONE, EX_PC, EX_SP, EX_PSTAT, EX_DES, EX_AES, EX_MOD,
                              EX_EELIGHT, EX_ECC, EX_STACK} fmr_exc_t;

    typedef struct packed {
        logic light;
        logic temp;
        logic freq;
        logic volt;
    } fmr_alarm_t;

    typedef struct packed {
        logic modarith;
        logic aes;
        logic des;
        logic program_status_high;
        logic sp;
        logic pc;
    } fmr_fault_t;

    // Check bits of a byte, single-error-correcting code
    function automatic logic [3:0] fmr_ecc_gen(input logic [7:0] d);
        fmr_ecc_gen[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        fmr_ecc_gen[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        fmr_ecc_gen[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        fmr_ecc_gen[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    endfunction

    // Syndrome that points at each data bit
    function automatic logic [3:0] fmr_ecc_pos(input int i);
        case (i)
            0:       fmr_ecc_pos = 4'h3;
            1:       fmr_ecc_pos = 4'h5;
            2:       fmr_ecc_pos = 4'h6;
            3:       fmr_ecc_pos = 4'h7;
            4:       fmr_ecc_pos = 4'h9;
            5:       fmr_ecc_pos = 4'ha;
            6:       fmr_ecc_pos = 4'hb;
            default: fmr_ecc_pos = 4'hc;
        endcase
    endfunction

endpackage

/* File: design/fmr_ecc_fix.sv */
// Per-byte single-bit corrector for the EEPROM read path.
// Assumes data and check bits arrive together on one valid cycle.
`timescale 1ns/100ps
`default_nettype none
module fmr_ecc_fix
    import fmr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    input  wire logic [3:0] chk_i,
    output logic            valid_o,
    output logic [7:0]      data_o,
    output logic            err_o
);
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       err;
    } fmr_fix_t;

    fmr_fix_t st;
    fmr_fix_t next_st;

    always_comb
    begin
        logic [3:0] syn;
        syn = chk_i ^ fmr_ecc_gen(data_i);
        next_st.valid = valid_i;
        next_st.data = data_i;
        next_st.err = valid_i && (syn != 4'h0);
        // A flipped check bit leaves the data alone but still counts as an error
        for (int i = 0; i < 8; i++)
        begin
            if (syn == fmr_ecc_pos(i))
            begin
                next_st.data[i] = ~data_i[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign valid_o = st.valid;
    assign data_o  = st.data;
    assign err_o   = st.err;
endmodule // fmr_ecc_fix
`default_nettype wire

/* File: design/fmr_stack_chk.sv */
// Range checker for one stack pointer.
// Assumes the pointer and its limit share the system clock.
`timescale 1ns/100ps
`default_nettype none
module fmr_stack_chk
    import fmr_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] sp_i,
    input  wire logic [W-1:0] limit_i,
    output logic              hit_o
);
    typedef struct packed {
        logic hit;
    } fmr_chk_t;

    fmr_chk_t st;
    fmr_chk_t next_st;

    always_comb
    begin
        // Reaching the limit counts, not only passing it
        next_st.hit = (sp_i >= limit_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hit_o = st.hit;
endmodule // fmr_stack_chk
`default_nettype wire

/* File: design/fmr_monitor.sv */
// Fault and operating-condition monitor: reset requests, exceptions, cause registers.
// Assumes sensor alarms and light detectors are asynchronous pins; core signals share clk_i.
`timescale 1ns/100ps
`default_nettype none
module fmr_monitor
    import fmr_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [AW-1:0]    addr_i,
    input  wire logic [DW-1:0]    wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic [DW-1:0]         rdata_o,
    input  wire fmr_alarm_t       alarm_i,
    input  wire fmr_fault_t       fault_i,
    input  wire logic             test_mode_i,
    input  wire logic [1:0]       cpu_mode_i,
    input  wire logic [2:0][7:0]  sp_i,
    input  wire logic [1:0]       ee_light_i,
    input  wire logic             ee_rd_valid_i,
    input  wire logic [7:0]       ee_data_i,
    input  wire logic [3:0]       ee_chk_i,
    output logic                  ee_valid_o,
    output logic [7:0]            ee_data_o,
    input  wire logic             ee_wr_end_i,
    input  wire logic             ee_hv_ok_i,
    input  wire logic             rom_rd_i,
    input  wire logic [7:0]       rom_data_i,
    input  wire logic             rom_par_i,
    output logic                  reset_req_o,
    output logic                  exc_o,
    output logic                  sensor_en_o,
    output logic                  irq_o
);
    typedef struct packed {
        fmr_alarm_t     a1;
        fmr_alarm_t     a2;
        logic [1:0]     l1;
        logic [1:0]     l2;
        logic           hv1;
        logic           hv2;
        logic [7:0]     ctrl;
        logic [7:0]     stat;
        logic [7:0]     mask;
        logic [1:0]     hv;
        logic [2:0][7:0] lim;
        fmr_rcause_t    rcause;
        fmr_exc_t       excr;
        logic [8:0]     prev;
        logic           rreq;
        logic           exc;
        logic           sen;
        logic           irq;
        logic [7:0]     rdata;
    } fmr_mon_t;

    fmr_mon_t   st;
    fmr_mon_t   next_st;
    logic [2:0] hit;
    logic       ecc_err;
    logic       rom_err;
    logic [8:0] src;
    logic [8:0] nw;
    logic       rst_src;

    fmr_ecc_fix u_fix (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .valid_i (ee_rd_valid_i),
        .data_i  (ee_data_i),
        .chk_i   (ee_chk_i),
        .valid_o (ee_valid_o),
        .data_o  (ee_data_o),
        .err_o   (ecc_err)
    );

    for (genvar g = 0; g < 3; g++)
    begin : g_stk
        fmr_stack_chk #(.W(8)) u_chk (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .sp_i    (sp_i[g]),
            .limit_i (st.lim[g]),
            .hit_o   (hit[g])
        );
    end

    // Odd parity over data and parity bit
    assign rom_err = rom_rd_i && !(^{rom_data_i, rom_par_i});

    always_comb
    begin
        logic [1:0] mi;
        logic       light;
        logic [7:0] clr;
        mi = 2'h0;
        light = 1'b0;
        clr = 8'h00;
        next_st = st;
        mi = (cpu_mode_i == 2'h0) ? 2'h0 : (cpu_mode_i == 2'h1) ? 2'h1 : 2'h2;
        // Second stage alone reads the first
        next_st.a1 = alarm_i;
        next_st.a2 = st.a1;
        next_st.l1 = ee_light_i;
        next_st.l2 = st.l1;
        next_st.hv1 = ee_hv_ok_i;
        next_st.hv2 = st.hv1;

        case (st.ctrl[CTRL_SEL_LSB +: 2])
            SEL_A:   light = st.l2[0];
            SEL_B:   light = st.l2[1];
            default: light = 1'b0;
        endcase

        src[0] = fault_i.pc;
        src[1] = fault_i.sp;
        src[2] = fault_i.program_status_high;
        src[3] = fault_i.des;
        src[4] = fault_i.aes;
        src[5] = fault_i.modarith;
        src[6] = light;
        // correction error when inverse mode on
        src[7] = st.ctrl[CTRL_INV] && ecc_err;
        // only the active mode's pointer counts
        src[8] = hit[mi];
        nw = src & ~st.prev;
        next_st.prev = src;

        rst_src = (|st.a2) || rom_err;
        // reset request held while a cause persists
        next_st.rreq = rst_src;
        // cause caught on the first cycle of a request
        if (rst_src && !st.rreq)
        begin
            if (st.a2.volt)
                next_st.rcause = RC_VOLT;
            else if (st.a2.freq)
                next_st.rcause = RC_FREQ;
            else if (st.a2.temp)
                next_st.rcause = RC_TEMP;
            else if (st.a2.light)
                next_st.rcause = RC_LIGHT;
            else
                next_st.rcause = RC_ROM;
        end

        // lowest source index wins the reason
        next_st.exc = |nw;
        for (int i = 8; i >= 0; i--)
        begin
            if (nw[i])
            begin
                next_st.excr = fmr_exc_t'(4'(i + 1));
            end
        end

        if (ee_wr_end_i)
        begin
            next_st.hv = {1'b1, st.hv2};
        end

        next_st.sen = !test_mode_i;

        clr = 8'h00;
        if (wr_i)
        begin
            unique case (addr_i)
                // sensor enable bits are not stored
                A_CTRL:  next_st.ctrl = {4'h0, 1'b0, wdata_i[CTRL_INV], wdata_i[CTRL_SEL_LSB +: 2]};
                A_STAT:  clr = wdata_i;
                A_MASK:  next_st.mask = wdata_i;
                A_LIM0:  next_st.lim[0] = wdata_i;
                4'h7:    next_st.lim[1] = wdata_i;
                4'h8:    next_st.lim[2] = wdata_i;
                default: clr = 8'h00;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_st.stat = st.stat & ~clr;
        next_st.stat[ST_EXC] = next_st.stat[ST_EXC] | (|nw);
        next_st.stat[ST_CORR] = next_st.stat[ST_CORR] | ecc_err;
        next_st.irq = |(next_st.stat & st.mask);

        next_st.rdata = 8'h00;
        if (rd_i)
        begin
            unique case (addr_i)
                A_CTRL:   next_st.rdata = {{4{st.sen}}, st.ctrl[3:0]};
                A_RCAUSE: next_st.rdata = {5'h00, st.rcause};
                A_EXCR:   next_st.rdata = {4'h0, st.excr};
                A_STAT:   next_st.rdata = st.stat;
                A_MASK:   next_st.rdata = st.mask;
                A_HV:     next_st.rdata = {6'h00, st.hv};
                A_LIM0:   next_st.rdata = st.lim[0];
                4'h7:     next_st.rdata = st.lim[1];
                4'h8:     next_st.rdata = st.lim[2];
                default:  next_st.rdata = 8'h00;
            endcase
        end
    end

    // every field takes its reset value
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.ctrl <= CTRL_RST;
            st.mask <= MASK_RST;
            st.lim <= {3{LIM_RST}};
            st.rcause <= RC_POR;
            st.excr <= EX_NONE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_o     = st.rdata;
    assign reset_req_o = st.rreq;
    assign exc_o       = st.exc;
    assign sensor_en_o = st.sen;
    assign irq_o       = st.irq;

    sequence new_fault_s;
        |(src & ~st.prev);
    endsequence

    sequence exc_seen_s;
        exc_o && (st.excr != EX_NONE) && st.stat[ST_EXC];
    endsequence

    alarm_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|st.a2) |=> reset_req_o)
        else $error("alarm did not request reset");

    fault_exc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        new_fault_s |=> exc_seen_s)
        else $error("fault did not raise exception");

    des_cover_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (fault_i.des && !st.prev[3] && !(|st.prev[2:0]) && !(|fault_i[2:0]))
        |=> (st.excr == EX_DES))
        else $error("coprocessor fault reason wrong");

    reset_clear_a: assert property (@(posedge clk_i)
        rst_i |=> !reset_req_o && !exc_o && !irq_o && st.rcause == RC_POR)
        else $error("reset values wrong");

    rom_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rom_err && !(|st.a2) && !st.rreq) |=> (st.rcause == RC_ROM) && reset_req_o)
        else $error("rom parity cause wrong");

    ecc_exc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctrl[CTRL_INV] && ecc_err && !st.prev[7]) |=> exc_o)
        else $error("correction error missed");

    sensor_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !test_mode_i |=> sensor_en_o)
        else $error("sensors off outside test mode");

    sensor_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_i && addr_i == A_CTRL && !test_mode_i) |=> sensor_en_o)
        else $error("write disabled sensors");

    hv_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ee_wr_end_i |=> st.hv[1] && (st.hv[0] == $past(st.hv2)))
        else $error("hv result not latched");

    rom_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rom_err |=> reset_req_o)
        else $error("parity error did not reset");

    cause_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(rst_src && !st.rreq) |=> $stable(st.rcause))
        else $error("reset cause changed");

    sequence stack_hit_s;
        (cpu_mode_i == 2'h0) && hit[0] && !st.prev[8];
    endsequence

    volt_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.a2.volt && !st.rreq) |=> (st.rcause == RC_VOLT))
        else $error("voltage cause not recorded");

    cause_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == A_RCAUSE) |=> (rdata_o == {5'h00, $past(st.rcause)}))
        else $error("reset cause read wrong");

    hold_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (src == st.prev) |=> !exc_o)
        else $error("held source raised exception again");

    light_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctrl[CTRL_SEL_LSB +: 2] == SEL_B && st.l2[1] && !st.prev[6]) |=> exc_o)
        else $error("selected light function missed");

    stack_exc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stack_hit_s |=> exc_o)
        else $error("stack limit missed");

    hv_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ee_wr_end_i && !(|nw)) |=> !exc_o)
        else $error("hv check raised exception");

    ctrl_sen_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == A_CTRL && sensor_en_o) |=> (rdata_o[7:4] == 4'hf))
        else $error("sensor enable read wrong");

    fixed_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!(|st.a2) && !rom_err) |=> !reset_req_o)
        else $error("reset without alarm or parity");

    ee_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ee_rd_valid_i |=> ee_valid_o)
        else $error("corrected byte not delivered");
endmodule // fmr_monitor
`default_nettype wire

/* File: tb/fmr_env_model.sv */
// Far-side model: sensor pins and core fault detectors of the monitor.
// Assumes one bench process calls its tasks, one at a time.
`timescale 1ns/100ps
`default_nettype none
module fmr_env_model
    import fmr_pkg::*;
(
    input  wire logic       clk_i,
    output var fmr_alarm_t  alarm_o,
    output var fmr_fault_t  fault_o,
    output var logic [1:0]  light_o,
    output var logic        hv_ok_o
);
    initial
    begin
        alarm_o = '0;
        fault_o = '0;
        light_o = '0;
        hv_ok_o = 1'b0;
    end
    // Pins move just after an edge; the monitor still syncs them as if asynchronous
    task automatic sense(input fmr_alarm_t a, input logic [1:0] l, input logic v);
        @(posedge clk_i);
        alarm_o <= a;
        light_o <= l;
        hv_ok_o <= v;
    endtask
    // Detectors hold a fault as a level until the bench drops it
    task automatic core(input fmr_fault_t f);
        @(posedge clk_i);
        fault_o <= f;
    endtask
endmodule // fmr_env_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the fault monitor top.
// Assumes fmr_pkg and the far-side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb
    import fmr_pkg::*;
;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic [3:0]       addr_i = '0;
    logic [7:0]       wdata_i = '0;
    logic             wr_i = 1'b0;
    logic             rd_i = 1'b0;
    logic [7:0]       rdata_o;
    fmr_alarm_t       alarm_i;
    fmr_fault_t       fault_i;
    logic             test_mode_i = 1'b0;
    logic [1:0]       cpu_mode_i = '0;
    logic [2:0][7:0]  sp_i = '0;
    logic [1:0]       ee_light_i;
    logic             ee_rd_valid_i = 1'b0;
    logic [7:0]       ee_data_i = '0;
    logic [3:0]       ee_chk_i = '0;
    logic             ee_valid_o;
    logic [7:0]       ee_data_o;
    logic             ee_wr_end_i = 1'b0;
    logic             ee_hv_ok_i;
    logic             rom_rd_i = 1'b0;
    logic [7:0]       rom_data_i = '0;
    logic             rom_par_i = 1'b0;
    logic             reset_req_o;
    logic             exc_o;
    logic             sensor_en_o;
    logic             irq_o;
    integer           seed = 52;
    int               error_cnt = 0;
    int               n_tests = 0;
    int               ce;
    int               cr;
    int               e;
    int               j;
    logic [5:0]       f;
    logic [3:0]       a;
    logic [7:0]       d;
    logic [7:0]       lim;
    logic             b;
    logic             v;

    always #4 clk_i = ~clk_i;

    fmr_env_model m_env (.clk_i(clk_i), .alarm_o(alarm_i), .fault_o(fault_i), .light_o(ee_light_i),
                         .hv_ok_o(ee_hv_ok_i));

    fmr_monitor u_fmr_monitor (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .alarm_i(alarm_i), .fault_i(fault_i),
        .test_mode_i(test_mode_i), .cpu_mode_i(cpu_mode_i), .sp_i(sp_i), .ee_light_i(ee_light_i),
        .ee_rd_valid_i(ee_rd_valid_i), .ee_data_i(ee_data_i), .ee_chk_i(ee_chk_i), .ee_valid_o(ee_valid_o),
        .ee_data_o(ee_data_o), .ee_wr_end_i(ee_wr_end_i), .ee_hv_ok_i(ee_hv_ok_i), .rom_rd_i(rom_rd_i),
        .rom_data_i(rom_data_i), .rom_par_i(rom_par_i), .reset_req_o(reset_req_o), .exc_o(exc_o),
        .sensor_en_o(sensor_en_o), .irq_o(irq_o));

    // Lowest set source wins, coded from 1 upward
    function automatic logic [7:0] first1(input logic [7:0] x);
        first1 = 8'h00;
        for (int i = 7; i >= 0; i--)
            if (x[i])
                first1 = 8'(i + 1);
    endfunction

    function automatic logic [3:0] ecc(input logic [7:0] x);
        ecc = {^x[7:4], ^{x[7], x[3:1]}, ^{x[6:5], x[3:2], x[0]}, ^{x[6], x[4:3], x[1:0]}};
    endfunction

    task automatic wr(input logic [3:0] ad, input logic [7:0] val);
        @(posedge clk_i);
        addr_i  <= ad;
        wdata_i <= val;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] ad, input logic [7:0] ex);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 `CHK("rdata", ex, rdata_o)
    endtask

    // Windowed counts, since exception latency differs per source
    task automatic cnt(input int n);
        ce = 0;
        cr = 0;
        repeat (n)
        begin
            @(posedge clk_i);
            #1;
            ce += int'(exc_o === 1'b1);
            cr += int'(reset_req_o === 1'b1);
        end
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #300000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(A_RCAUSE, RC_POR);
        rchk(A_EXCR, EX_NONE);
        rchk(A_HV, 8'h00);
        rchk(A_LIM0 + 4'h2, LIM_RST);
        wr(A_CTRL, 8'h00);
        wr(4'hf, 8'hff);
        rchk(4'hf, 8'h00);
        rchk(A_CTRL, 8'hf0);
        for (int t = 1; t >= 0; t--)
        begin
            @(posedge clk_i);
            test_mode_i <= t[0];
            @(posedge clk_i);
            #1 `CHK("sensor_en", !t[0], sensor_en_o)
        end
        wr(A_MASK, 8'h01);
        for (int k = 0; k < 16; k++)
        begin
            f = (k < 6) ? 6'(1 << k) : 6'($random(seed));
            if (f == 6'h00)
                f = 6'h20;
            m_env.core(f);
            @(posedge clk_i);
            #1 `CHK("exc", 1'b1, exc_o)
            cnt(3);
            `CHK("exc_held", 0, ce)
            `CHK("no_reset", 0, cr)
            rchk(A_EXCR, first1(8'(f)));
            `CHK("irq", 1'b1, irq_o)
            wr(A_STAT, 8'h01);
            m_env.core('0);
            cnt(2);
            `CHK("irq_clr", 1'b0, irq_o)
        end
        wr(A_MASK, 8'h00);
        m_env.core(6'h04);
        cnt(3);
        `CHK("irq_mask", 1'b0, irq_o)
        rchk(A_STAT, 8'h01);
        m_env.core('0);
        for (int k = 0; k < 10; k++)
        begin
            a = (k < 4) ? 4'(1 << k) : 4'($random(seed));
            if (a == 4'h0)
                a = 4'h8;
            m_env.sense(a, 2'h0, 1'b0);
            cnt(4);
            `CHK("rst_req", 2, cr)
            `CHK("no_exc", 0, ce)
            rchk(A_RCAUSE, first1(8'(a)));
            m_env.sense('0, 2'h0, 1'b0);
            cnt(6);
            rchk(A_RCAUSE, first1(8'(a)));
        end
        for (int k = 0; k < 16; k++)
        begin
            d = 8'($random(seed));
            b = (k < 2) ? k[0] : 1'($random(seed));
            @(posedge clk_i);
            rom_rd_i   <= 1'b1;
            rom_data_i <= d;
            rom_par_i  <= ~^d ^ b;
            @(posedge clk_i);
            rom_rd_i   <= 1'b0;
            #1 `CHK("rom_rst", b, reset_req_o)
            cnt(1);
            `CHK("rom_rst_len", 0, cr)
            if (b)
                rchk(A_RCAUSE, RC_ROM);
        end
        for (int k = 0; k < 18; k++)
        begin
            if (k % 9 == 0)
                wr(A_CTRL, (k == 0) ? 8'h00 : 8'h04);
            d = 8'($random(seed));
            e = (k < 9) ? k : ((k == 17) ? 3 : {$random(seed)} % 9);
            @(posedge clk_i);
            ee_rd_valid_i <= 1'b1;
            ee_data_i     <= d ^ ((e < 8) ? 8'(1 << e) : 8'h00);
            ee_chk_i      <= ecc(d);
            @(posedge clk_i);
            ee_rd_valid_i <= 1'b0;
            #1 `CHK("ee_valid", 1'b1, ee_valid_o)
            `CHK("ee_data", d, ee_data_o)
            cnt(3);
            `CHK("ecc_exc", (k > 8 && e < 8), ce)
        end
        rchk(A_EXCR, EX_ECC);
        for (int s = 0; s < 4; s++)
        begin
            wr(A_CTRL, 8'(s));
            for (int l = 1; l < 3; l++)
            begin
                m_env.sense('0, 2'(l), 1'b0);
                cnt(6);
                `CHK("light_exc", (s == l), ce)
                `CHK("light_rst", 0, cr)
                m_env.sense('0, 2'h0, 1'b0);
                cnt(4);
            end
        end
        rchk(A_EXCR, EX_EELIGHT);
        for (int k = 0; k < 4; k++)
        begin
            v = (k < 2) ? k[0] : 1'($random(seed));
            m_env.sense('0, 2'h0, v);
            cnt(3);
            @(posedge clk_i);
            ee_wr_end_i <= 1'b1;
            @(posedge clk_i);
            ee_wr_end_i <= 1'b0;
            cnt(2);
            `CHK("hv_exc", 0, ce)
            rchk(A_HV, {6'h00, 1'b1, v});
        end
        // Parking the next pointer at the top shows only the active checker counts
        for (int m = 0; m < 4; m++)
        begin
            // Mode 3 runs on the super-system pointer, like mode 2
            j = (m > 2) ? 2 : m;
            lim = 8'h10 + 8'({$random(seed)} % 224);
            wr(A_LIM0 + 4'(j), lim);
            @(posedge clk_i);
            cpu_mode_i        <= 2'(m);
            sp_i[(j + 1) % 3] <= 8'hff;
            cnt(4);
            `CHK("stk_idle", 0, ce)
            @(posedge clk_i);
            sp_i[j] <= lim - 8'h01;
            cnt(4);
            `CHK("stk_below", 0, ce)
            @(posedge clk_i);
            sp_i[j] <= lim;
            cnt(4);
            `CHK("stk_hit", 1, ce)
            rchk(A_EXCR, EX_STACK);
            @(posedge clk_i);
            sp_i <= '0;
            cnt(2);
        end
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(A_RCAUSE, RC_POR);
        rchk(A_EXCR, EX_NONE);
        rchk(A_STAT, 8'h00);
        rchk(A_LIM0, LIM_RST);
        rchk(A_CTRL, 8'hf0);
        end_of_test();
    end
endmodule // tb
`undef CHK
`default_nettype wire
